//--- src/pseq_pkg.sv
// constants and types shared by the power sequencer design
package pseq_pkg;
	// clock and timebase rates
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TIMEBASE_HZ = 32_768;
	localparam int unsigned MS_PER_S = 1_000;
	localparam int unsigned BAUD = 9_600;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
	localparam int unsigned DATA_BITS = 8;
	// rails and delay range in milliseconds
	localparam int unsigned NUM_RAILS = 4;
	localparam int unsigned DELAY_W = 10;
	localparam int unsigned TICK_W = 16;
	localparam int unsigned ACC_W = 26;
	localparam int unsigned BIT_CNT_W = 16;
	localparam logic [DELAY_W-1:0] DELAY_MIN_MS = 10'h001;
	localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 10'h3E8;
	// host message codes
	localparam logic [7:0] CMD_READ = 8'h52;
	localparam logic [7:0] CMD_WRITE = 8'h57;
	localparam logic [7:0] REPLY_ACK = 8'h06;
	localparam logic [7:0] REPLY_NAK = 8'h15;
	localparam logic [2:0] LAST_BYTE = 3'h7;
	typedef logic [DELAY_W-1:0] delay_t;
	typedef delay_t [NUM_RAILS-1:0] delay_set_t;
	typedef logic [TICK_W-1:0] ticks_t;
endpackage

//--- src/serial_link_if.sv
// byte carrier between the sequencer core and its serial engine
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
	logic rx_valid;
	logic [7:0] rx_data;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_data;
	modport engine(output rx_valid, output rx_data, input tx_valid, output tx_ready,
		input tx_data);
	modport core(input rx_valid, input rx_data, output tx_valid, input tx_ready,
		output tx_data);
endinterface
`default_nettype wire

//--- src/uart_engine.sv
// 8n1 serial receiver and transmitter for the host link
`timescale 1ns/10ps
`default_nettype none
module uart_engine #(
	parameter int unsigned BIT_CYCLES = pseq_pkg::BIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_i,
	output logic tx_o,
	serial_link_if.engine link
);
	import pseq_pkg::*;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;

	localparam logic [BIT_CNT_W-1:0] FULL_BIT = BIT_CNT_W'(BIT_CYCLES - 1);
	localparam logic [BIT_CNT_W-1:0] HALF_BIT = BIT_CNT_W'(BIT_CYCLES / 2);
	localparam logic [3:0] RX_LAST = 4'h7;
	localparam logic [3:0] TX_FRAME = 4'hA;

	logic rx_meta, rx_sync;
	rx_state_t rx_state;
	logic [BIT_CNT_W-1:0] rx_cnt, tx_cnt;
	logic [3:0] rx_bits, tx_left;
	logic [7:0] rx_shift;
	logic [9:0] tx_shift;

	// two-stage synchroniser on the receive pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rx_i;
			rx_sync <= rx_meta;
		end
	end

	// receiver: sample mid bit, lsb first, one stop bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			link.rx_valid <= 1'b0;
			link.rx_data <= '0;
		end else begin
			link.rx_valid <= 1'b0;
			unique case (rx_state)
				RX_IDLE: begin
					rx_cnt <= '0;
					if (!rx_sync) rx_state <= RX_START;
				end
				RX_START: begin
					if (rx_cnt == HALF_BIT) begin
						rx_cnt <= '0;
						rx_bits <= '0;
						rx_state <= rx_sync ? RX_IDLE : RX_DATA; // glitch rejected
					end else rx_cnt <= rx_cnt + 1'b1;
				end
				RX_DATA: begin
					if (rx_cnt == FULL_BIT) begin
						rx_cnt <= '0;
						rx_shift <= {rx_sync, rx_shift[7:1]};
						rx_bits <= rx_bits + 1'b1;
						if (rx_bits == RX_LAST) rx_state <= RX_STOP;
					end else rx_cnt <= rx_cnt + 1'b1;
				end
				RX_STOP: begin
					if (rx_cnt == FULL_BIT) begin
						rx_state <= RX_IDLE;
						link.rx_valid <= rx_sync; // framing error drops byte
						link.rx_data <= rx_shift;
					end else rx_cnt <= rx_cnt + 1'b1;
				end
			endcase
		end
	end

	// transmitter: start, 8 data lsb first, stop, no parity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_shift <= '1;
			tx_left <= '0;
			tx_cnt <= '0;
		end else if (tx_left == '0) begin
			if (link.tx_valid) begin
				tx_shift <= {1'b1, link.tx_data, 1'b0};
				tx_left <= TX_FRAME;
				tx_cnt <= '0;
			end
		end else if (tx_cnt == FULL_BIT) begin
			tx_cnt <= '0;
			tx_shift <= {1'b1, tx_shift[9:1]};
			tx_left <= tx_left - 1'b1;
		end else tx_cnt <= tx_cnt + 1'b1;
	end

	assign tx_o = tx_shift[0];
	assign link.tx_ready = (tx_left == '0);
endmodule
`default_nettype wire

//--- src/four_rail_power_sequencer.sv
// four rail power-on sequencer with serial host access to its delays
// ---------------------------------------------------------------
// Summary of operation
// - four separate power-on outputs, each raised at its own programmed moment.
// - idle until a rising enable edge, then start the counters.
// - counters step at 32.768 kHz derived from the reference timebase.
// - two counters with two compare values each, one per output.
// - counter reaching a compare value raises its output and holds it high.
// - each delay is measured from the detected enable edge.
// - delays lie between 1 and 1000 ms; a host write with any other value is refused.
// - delays kept in nonvolatile store and loaded after every reset.
// - host link is 9600 baud, no parity, one stop bit.
// - host reads current sequence and writes a new one for the next run.
// - startup indicator rises together with counter start on the enable edge.
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module four_rail_power_sequencer #(
	parameter int unsigned BIT_CYCLES = pseq_pkg::BIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic host_serial_rx_i,
	output logic host_serial_tx_o,
	input wire pseq_pkg::delay_set_t nv_delay_i,
	output pseq_pkg::delay_set_t nv_delay_o,
	output logic nv_write_o,
	output logic [pseq_pkg::NUM_RAILS-1:0] power_on_output_o,
	output logic startup_o
);
	import pseq_pkg::*;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN = 2'b01,
		SEQ_DONE = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		HOST_CMD = 2'b00,
		HOST_WRITE = 2'b01,
		HOST_SEND = 2'b10
	} host_state_t;

	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TIMEBASE_HZ);
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// milliseconds to timebase ticks, rounded up
	function automatic ticks_t ms_to_ticks(input delay_t ms);
		int unsigned t;
		t = (int'(ms) * TIMEBASE_HZ + MS_PER_S - 1) / MS_PER_S;
		return ticks_t'(t);
	endfunction

	function automatic logic in_range(input delay_t ms);
		return (ms >= DELAY_MIN_MS) && (ms <= DELAY_MAX_MS);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	serial_link_if link();
	seq_state_t seq_state;
	host_state_t host_state;
	logic en_meta, en_sync, en_prev, en_rise;
	logic loaded;
	logic [ACC_W-1:0] acc;
	logic tick;
	ticks_t count_a, count_b;
	ticks_t [NUM_RAILS-1:0] compare;
	delay_set_t active_ms, staged_ms, write_buf;
	logic [2:0] byte_idx;
	logic send_read;
	logic [7:0] reply;
	delay_t sel_ms;

	uart_engine #(
		.BIT_CYCLES(BIT_CYCLES)
	) uart_engine_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rx_i(host_serial_rx_i),
		.tx_o(host_serial_tx_o),
		.link(link.engine)
	);

	// ---------------------------------------------------------------
	// enable edge detection
	// ---------------------------------------------------------------
	// synchronise the enable pin, then find its rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_meta <= 1'b0;
			en_sync <= 1'b0;
			en_prev <= 1'b0;
		end else begin
			en_meta <= enable_i;
			en_sync <= en_meta;
			en_prev <= en_sync;
		end
	end

	assign en_rise = en_sync && !en_prev;

	// ---------------------------------------------------------------
	// sequence control
	// ---------------------------------------------------------------
	// idle until an edge, run until all rails are up, hold until reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_state <= SEQ_IDLE;
		end else begin
			unique case (seq_state)
				SEQ_IDLE: if (en_rise && loaded) seq_state <= SEQ_RUN;
				SEQ_RUN: if (&power_on_output_o) seq_state <= SEQ_DONE;
				SEQ_DONE: seq_state <= SEQ_DONE;
				default: seq_state <= SEQ_IDLE;
			endcase
		end
	end

	// startup indicator raised in the same cycle as the counters start
	always_ff @(posedge clk_i) begin
		if (rst_i) startup_o <= 1'b0;
		else if (seq_state == SEQ_IDLE && en_rise && loaded) startup_o <= 1'b1;
	end

	// fractional divider: one enable pulse per 32.768 kHz period
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_state != SEQ_RUN) begin
			acc <= '0; // restarts phase at the enable edge
			tick <= 1'b0;
		end else if (acc + ACC_STEP >= ACC_WRAP) begin
			acc <= acc + ACC_STEP - ACC_WRAP;
			tick <= 1'b1;
		end else begin
			acc <= acc + ACC_STEP;
			tick <= 1'b0;
		end
	end

	// counter a serves rails 0 and 1, counter b rails 2 and 3
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_state == SEQ_IDLE) begin
			count_a <= '0;
			count_b <= '0;
		end else if (tick) begin
			if (!(&power_on_output_o[1:0])) count_a <= count_a + 1'b1;
			if (!(&power_on_output_o[3:2])) count_b <= count_b + 1'b1;
		end
	end

	// compare match raises a rail and keeps it high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_on_output_o <= '0;
		end else if (seq_state == SEQ_RUN) begin
			for (int i = 0; i < NUM_RAILS; i++) begin
				if ((i < 2 ? count_a : count_b) >= compare[i])
					power_on_output_o[i] <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// delay storage
	// ---------------------------------------------------------------
	// load from nonvolatile store after reset; staged set applied on the edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loaded <= 1'b0;
			active_ms <= '0;
			staged_ms <= '0;
		end else if (!loaded) begin
			loaded <= 1'b1;
			active_ms <= nv_delay_i;
			staged_ms <= nv_delay_i;
		end else begin
			if (seq_state == SEQ_IDLE && en_rise) active_ms <= staged_ms;
			if (nv_write_o) staged_ms <= nv_delay_o;
		end
	end

	// compare values follow the set in use for this run
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare <= '1;
		end else begin
			for (int i = 0; i < NUM_RAILS; i++)
				compare[i] <= ms_to_ticks(active_ms[i]);
		end
	end

	// ---------------------------------------------------------------
	// host protocol
	// ---------------------------------------------------------------
	// read: 8 bytes, write: 8 bytes then ack or nak; high byte first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_state <= HOST_CMD;
			byte_idx <= '0;
			send_read <= 1'b0;
			reply <= '0;
			write_buf <= '0;
			nv_delay_o <= '0;
			nv_write_o <= 1'b0;
		end else begin
			nv_write_o <= 1'b0;
			unique case (host_state)
				HOST_CMD: begin
					byte_idx <= '0;
					if (link.rx_valid && link.rx_data == CMD_READ) begin
						send_read <= 1'b1;
						host_state <= HOST_SEND;
					end else if (link.rx_valid && link.rx_data == CMD_WRITE) begin
						host_state <= HOST_WRITE;
					end
				end
				HOST_WRITE: if (link.rx_valid) begin
					if (byte_idx[0]) write_buf[byte_idx[2:1]][7:0] <= link.rx_data;
					else write_buf[byte_idx[2:1]][DELAY_W-1:8] <= link.rx_data[1:0];
					byte_idx <= byte_idx + 1'b1;
					if (byte_idx == LAST_BYTE) begin
						send_read <= 1'b0;
						host_state <= HOST_SEND;
						reply <= REPLY_ACK;
					end
				end
				HOST_SEND: begin
					if (send_read && link.tx_ready) begin
						byte_idx <= byte_idx + 1'b1;
						if (byte_idx == LAST_BYTE) host_state <= HOST_CMD;
					end else if (!send_read) begin
						// out of range values refuse the whole write
						if (!(in_range(write_buf[0]) && in_range(write_buf[1])
							&& in_range(write_buf[2]) && in_range(write_buf[3]))) begin
							reply <= REPLY_NAK;
						end else if (reply == REPLY_ACK && link.tx_ready) begin
							nv_delay_o <= write_buf;
							nv_write_o <= 1'b1;
						end
						// leave only once the reply byte is taken; a nak needs one extra cycle
						if (link.tx_valid && link.tx_ready) host_state <= HOST_CMD;
					end
				end
				default: host_state <= HOST_CMD;
			endcase
		end
	end

	// byte offered to the transmitter
	assign sel_ms = active_ms[byte_idx[2:1]];
	assign link.tx_valid = (host_state == HOST_SEND)
		&& (send_read || !(&{in_range(write_buf[0]), in_range(write_buf[1]),
			in_range(write_buf[2]), in_range(write_buf[3])}) == (reply == REPLY_NAK));
	assign link.tx_data = !send_read ? reply
		: byte_idx[0] ? sel_ms[7:0] : {6'h00, sel_ms[DELAY_W-1:8]};
endmodule
`default_nettype wire

//--- verif/pseq_assertions.sv
// port-level assertions for the power sequencer
`timescale 1ns/10ps
`default_nettype none
module pseq_assertions #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic host_serial_rx_i,
	input wire logic host_serial_tx_o,
	input wire pseq_pkg::delay_set_t nv_delay_i,
	input wire pseq_pkg::delay_set_t nv_delay_o,
	input wire logic nv_write_o,
	input wire logic [pseq_pkg::NUM_RAILS-1:0] power_on_output_o,
	input wire logic startup_o
);
	import pseq_pkg::*;
	logic [16:0] since;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// cycles since the startup indicator rose
	always_ff @(posedge clk_i) begin
		if (rst_i || !startup_o) since <= 17'h00000;
		else if (since != 17'h1FFFF) since <= since + 17'h00001;
	end
	// every delay of a set within the legal range
	function automatic logic ok_set(input delay_set_t d);
		ok_set = 1'b1;
		for (int i = 0; i < NUM_RAILS; i++) begin
			if (d[i] < DELAY_MIN_MS || d[i] > DELAY_MAX_MS) ok_set = 1'b0;
		end
	endfunction
	a_reset_quiets_outputs: assert property (disable iff (1'b0)
		rst_i |=> power_on_output_o == 4'h0 && !startup_o && host_serial_tx_o)
		else $error("outputs not quiet after reset");
	a_startup_stays_high: assert property (startup_o |=> startup_o)
		else $error("startup indicator dropped");
	a_rails_stay_high: assert property (($past(power_on_output_o) & ~power_on_output_o) == 4'h0)
		else $error("rail output dropped");
	a_rail_needs_start: assert property (power_on_output_o != 4'h0 |-> startup_o)
		else $error("rail high without a run");
	a_start_on_edge: assert property ($rose(startup_o) |-> $past(enable_i, 3) && !$past(enable_i, 4))
		else $error("run started without an enable edge");
	a_rail_min_delay: assert property (
		(power_on_output_o & ~$past(power_on_output_o)) != 4'h0 |-> since >= 17'h0C47C)
		else $error("rail rose before the shortest delay");
	a_store_one_pulse: assert property (nv_write_o |=> !nv_write_o)
		else $error("store strobe longer than one cycle");
	a_store_in_range: assert property (nv_write_o |-> ##1 ok_set(nv_delay_o))
		else $error("out of range set stored");
	cover property ($rose(startup_o));
	cover property (power_on_output_o == 4'hF);
	cover property (nv_write_o);
endmodule
`default_nettype wire

//--- verif/host_side_model.sv
// host serial port and nonvolatile store beside the sequencer
`timescale 1ns/10ps
`default_nettype none
module host_side_model #(
	parameter int unsigned BIT_CYCLES = 16,
	parameter pseq_pkg::delay_set_t INIT = '0
) (
	input wire logic clk_i,
	input wire logic serial_i,
	output logic serial_o,
	input wire logic nv_write_i,
	input wire pseq_pkg::delay_set_t nv_new_i,
	output pseq_pkg::delay_set_t nv_store_o
);
	import pseq_pkg::*;
	initial nv_store_o = INIT;
	initial serial_o = 1'b1;
	// store keeps a written set across resets
	always @(posedge clk_i) begin
		if (nv_write_i === 1'b1) nv_store_o <= nv_new_i;
	end
	// one frame: start, eight bits lsb first, one stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_o <= f[i];
			repeat (BIT_CYCLES) @(posedge clk_i);
		end
	endtask
	// bounded wait for a start bit, then mid-bit sampling
	task automatic recv_byte(output logic [7:0] b);
		int n;
		b = 'x;
		n = 0;
		while (serial_i !== 1'b0 && n < 120 * BIT_CYCLES) begin
			@(posedge clk_i);
			n++;
		end
		if (serial_i !== 1'b0) return;
		repeat (BIT_CYCLES / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk_i);
			b[i] = serial_i;
		end
		repeat (BIT_CYCLES) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- verif/four_rail_power_sequencer_bench.sv
// self-checking bench for the four rail power sequencer
`timescale 1ns/10ps
`default_nettype none
module four_rail_power_sequencer_bench;
	import pseq_pkg::*;
	localparam int unsigned BITC = 16;
	localparam delay_set_t INIT = {10'h3E8, 10'h1F4, 10'h003, 10'h007};
	localparam delay_set_t RUNSET = {10'h002, 10'h001, 10'h002, 10'h001};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic enable_i = 1'b0;
	logic rx_line, tx_line, nv_write_o, startup_o;
	delay_set_t nv_in, nv_out;
	logic [NUM_RAILS-1:0] power_on_output_o;
	logic [7:0] reply [8];
	int failures = 0;
	int comparisons = 0;
	int writes = 0;
	always #10 clk_i = ~clk_i;
	four_rail_power_sequencer #(.BIT_CYCLES(BITC)) four_rail_power_sequencer_i (
		.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .host_serial_rx_i(rx_line),
		.host_serial_tx_o(tx_line), .nv_delay_i(nv_in), .nv_delay_o(nv_out),
		.nv_write_o(nv_write_o), .power_on_output_o(power_on_output_o), .startup_o(startup_o));
	host_side_model #(.BIT_CYCLES(BITC), .INIT(INIT)) host_side_model_i (
		.clk_i(clk_i), .serial_i(tx_line), .serial_o(rx_line), .nv_write_i(nv_write_o),
		.nv_new_i(nv_out), .nv_store_o(nv_in));
	// count store strobes
	always @(posedge clk_i) begin
		if (nv_write_o === 1'b1) writes++;
	end
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// byte i of a set on the wire: high bits first, rails in order
	function automatic logic [7:0] pack(input delay_set_t d, input int i);
		return i[0] ? d[i/2][7:0] : {6'h00, d[i/2][9:8]};
	endfunction
	// command with payload, reply collected meanwhile
	task automatic xfer(input logic [7:0] cmd, input delay_set_t d, input int tn, input int rn);
		fork
			begin
				host_side_model_i.send_byte(cmd);
				for (int i = 0; i < tn; i++) host_side_model_i.send_byte(pack(d, i));
			end
			for (int i = 0; i < rn; i++) host_side_model_i.recv_byte(reply[i]);
		join
	endtask
	// quiet outputs and no run without an enable edge
	task automatic t_idle();
		repeat (20) @(negedge clk_i);
		check("rails idle", power_on_output_o, 40'h0);
		check("startup idle", startup_o, 40'h0);
		check("tx idle", tx_line, 40'h1);
		@(posedge clk_i);
	endtask
	task automatic t_read(input delay_set_t exp);
		xfer(CMD_READ, exp, 0, 8);
		for (int i = 0; i < 8; i++) check("read byte", reply[i], pack(exp, i));
	endtask
	// a set with a value out of range is refused
	task automatic t_write(input delay_set_t d, input logic ok);
		int w;
		w = writes;
		xfer(CMD_WRITE, d, 8, 1);
		check("reply", reply[0], ok ? REPLY_ACK : REPLY_NAK);
		check("store strobes", writes - w, ok);
		if (ok) check("stored set", nv_out, d);
	endtask
	// one run, a refused second edge, then reset
	task automatic t_run();
		int n;
		enable_i <= 1'b1;
		n = 0;
		while (startup_o !== 1'b1 && n < 10) begin
			@(negedge clk_i);
			n++;
		end
		check("startup lag", n, 4);
		n = 0;
		while (power_on_output_o[0] !== 1'b1 && n < 60000) begin
			@(negedge clk_i);
			n++;
		end
		check("1 ms moment", n >= 50352 && n <= 50362, 1);
		check("rails at 1 ms", power_on_output_o, 40'h5);
		while (power_on_output_o[1] !== 1'b1 && n < 110000) begin
			@(negedge clk_i);
			n++;
		end
		check("2 ms moment", n >= 100706 && n <= 100716, 1);
		check("rails at 2 ms", power_on_output_o, 40'hF);
		@(posedge clk_i);
		enable_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		enable_i <= 1'b1;
		repeat (10) @(negedge clk_i);
		check("rails held", {startup_o, power_on_output_o}, 40'h1F);
		@(posedge clk_i);
		rst_i <= 1'b1;
		enable_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check("reset drops", {startup_o, power_on_output_o}, 40'h0);
		@(posedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_idle();
		t_read(INIT);
		t_write({10'h3E8, 10'h1F4, 10'h000, 10'h007}, 1'b0);
		t_write({10'h3E8, 10'h3E9, 10'h003, 10'h007}, 1'b0);
		t_write(RUNSET, 1'b1);
		t_read(INIT);
		t_run();
		t_read(RUNSET);
		conclude();
	end
	// watchdog
	initial begin
		#3000000;
		failures++;
		conclude();
	end
endmodule
bind four_rail_power_sequencer pseq_assertions #(.BIT_CYCLES(BIT_CYCLES)) pseq_assertions_i (
	.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .host_serial_rx_i(host_serial_rx_i),
	.host_serial_tx_o(host_serial_tx_o), .nv_delay_i(nv_delay_i), .nv_delay_o(nv_delay_o),
	.nv_write_o(nv_write_o), .power_on_output_o(power_on_output_o), .startup_o(startup_o));
`default_nettype wire
